// ===== verilog/remote_gate_pkg.sv
/*
  constants for the infrared remote gate: register map, field positions,
  reset values and command codes.
  assumes an axi4-lite master with 32-bit data on the same clock.
*/
package remote_gate_pkg;
  localparam logic [7:0] CFG_OFF    = 8'h00;
  localparam logic [7:0] BLOCK_OFF  = 8'h04;
  localparam logic [7:0] EVENT_OFF  = 8'h08;
  localparam logic [7:0] STATUS_OFF = 8'h0c;
  localparam logic [7:0] VALUE_OFF  = 8'h10;
  localparam int CFG_EN_BIT   = 0;
  localparam int CFG_TEST_BIT = 1;
  localparam int CFG_USE_BIT  = 2;
  localparam int CFG_POL_BIT  = 3;
  localparam int CFG_PRE_LSB  = 4;
  localparam int CFG_RET_LSB  = 6;
  localparam int CFG_DL_BIT   = 8;
  localparam logic [8:0] CFG_RESET = 9'h000;
  localparam logic [1:0] PRESET_ALL    = 2'h0;
  localparam logic [1:0] PRESET_NO_OFF = 2'h1;
  localparam logic [1:0] PRESET_NO_ON  = 2'h2;
  localparam logic [1:0] RET_ENABLED   = 2'h0;
  localparam logic [1:0] RET_DISABLED  = 2'h1;
  localparam logic [1:0] RET_KEEP      = 2'h2;
  localparam logic [2:0] CMD_ON       = 3'h0;
  localparam logic [2:0] CMD_AUTO     = 3'h1;
  localparam logic [2:0] CMD_OFF      = 3'h2;
  localparam logic [2:0] CMD_TEST     = 3'h3;
  localparam logic [2:0] CMD_TWILIGHT = 3'h4;
  localparam logic [2:0] CMD_SENS     = 3'h5;
  localparam logic [2:0] CMD_RUNON    = 3'h6;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : remote_gate_pkg

// ===== verilog/remote_control_gate.sv
/*
  gate for decoded infrared remote commands acting on motion block 1.
  assumes commands arrive as one-cycle pulses already on aclk, and that
  bus_fail / bus_return / download_done come from logic on aclk.
*/
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
module remote_control_gate
  import remote_gate_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // decoded remote command
  input  wire logic        ir_cmd_valid,
  input  wire logic [2:0]  ir_cmd_code,
  input  wire logic [7:0]  ir_cmd_value,
  // supply and download events
  input  wire logic        bus_fail,
  input  wire logic        bus_return,
  input  wire logic        download_done,
  // actions on motion block 1
  output logic             blk1_on_q,
  output logic             blk1_auto_q,
  output logic             blk1_off_q,
  output logic             walk_test_q,
  output logic             twilight_wr_q,
  output logic             sens_wr_q,
  output logic             runon_wr_q,
  output logic [7:0]       adj_value_q,
  output logic             remote_blocked_q
);

  logic [8:0] cfg_q;
  logic       saved_block_q;
  logic [7:0] accept_cnt_q;
  logic [7:0] reject_cnt_q;
  logic       aw_hold_q;
  logic       w_hold_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  logic       cfg_en;
  logic       cfg_test;
  logic       cfg_use;
  logic       cfg_pol;
  logic [1:0] cfg_pre;
  logic [1:0] cfg_ret;
  logic       cfg_dl;
  assign cfg_en   = cfg_q[CFG_EN_BIT];
  assign cfg_test = cfg_q[CFG_TEST_BIT];
  assign cfg_use  = cfg_q[CFG_USE_BIT];
  assign cfg_pol  = cfg_q[CFG_POL_BIT];
  assign cfg_pre  = cfg_q[CFG_PRE_LSB +: 2];
  assign cfg_ret  = cfg_q[CFG_RET_LSB +: 2];
  assign cfg_dl   = cfg_q[CFG_DL_BIT];

  // write channel: address and data may arrive in either order
  logic aw_have;
  logic w_have;
  logic wr_fire;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  assign aw_have = aw_hold_q | (s_axi_awvalid & s_axi_awready);
  assign w_have  = w_hold_q | (s_axi_wvalid & s_axi_wready);
  assign wr_fire = aw_have & w_have & ~s_axi_bvalid;
  assign wr_addr = aw_hold_q ? aw_addr_q : s_axi_awaddr;
  assign wr_data = w_hold_q ? w_data_q : s_axi_wdata;
  assign wr_strb = w_hold_q ? w_strb_q : s_axi_wstrb;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      aw_hold_q <= aw_have & ~wr_fire;
      w_hold_q  <= w_have & ~wr_fire;
      // ready only while nothing is held, so each side is taken once
      s_axi_awready <= ~s_axi_awready & ~(aw_have & ~wr_fire) & ~s_axi_bvalid;
      s_axi_wready  <= ~s_axi_wready & ~(w_have & ~wr_fire) & ~s_axi_bvalid;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_addr == CFG_OFF || wr_addr == BLOCK_OFF) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel: one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & s_axi_arvalid & ~s_axi_rvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        unique case (s_axi_araddr)
          CFG_OFF:    s_axi_rdata <= {23'h000000, cfg_q};
          BLOCK_OFF:  s_axi_rdata <= {31'h00000000, remote_blocked_q};
          EVENT_OFF:  s_axi_rdata <= 32'h0000_0000;
          STATUS_OFF: s_axi_rdata <= {16'h0000, reject_cnt_q, accept_cnt_q};
          VALUE_OFF:  s_axi_rdata <= {23'h000000, saved_block_q, adj_value_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= CFG_RESET;
    end else if (wr_fire && wr_addr == CFG_OFF) begin
      if (wr_strb[0]) cfg_q[7:0] <= wr_data[7:0];
      if (wr_strb[1]) cfg_q[8] <= wr_data[8];
    end
  end

  // disable object: written value as received, decoded by polarity
  logic obj_wr;
  logic obj_block;
  assign obj_wr    = wr_fire && wr_addr == BLOCK_OFF && wr_strb[0];
  assign obj_block = cfg_pol ? ~wr_data[0] : wr_data[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      remote_blocked_q <= 1'b0;
    end else if (!cfg_use) begin
      remote_blocked_q <= 1'b0;
    end else if (download_done) begin
      remote_blocked_q <= cfg_dl;
    end else if (bus_return) begin
      unique case (cfg_ret)
        RET_DISABLED: remote_blocked_q <= 1'b1;
        RET_KEEP:     remote_blocked_q <= saved_block_q;
        default:      remote_blocked_q <= 1'b0;
      endcase
    end else if (obj_wr) begin
      remote_blocked_q <= obj_block;
    end
  end

  // saved copy models the value kept through supply loss
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      saved_block_q <= 1'b0;
    end else if (bus_fail) begin
      saved_block_q <= remote_blocked_q;
    end
  end

  // gating; the disable write takes effect on the next cycle's command
  logic accept;
  logic mode_ok;
  always_comb begin
    unique case (ir_cmd_code)
      CMD_ON:   mode_ok = cfg_pre != PRESET_NO_ON;
      CMD_OFF:  mode_ok = cfg_pre != PRESET_NO_OFF;
      CMD_TEST: mode_ok = cfg_test;
      CMD_AUTO, CMD_TWILIGHT, CMD_SENS, CMD_RUNON: mode_ok = 1'b1;
      default:  mode_ok = 1'b0;
    endcase
  end
  assign accept = ir_cmd_valid & cfg_en & ~remote_blocked_q & mode_ok;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blk1_on_q     <= 1'b0;
      blk1_auto_q   <= 1'b0;
      blk1_off_q    <= 1'b0;
      twilight_wr_q <= 1'b0;
      sens_wr_q     <= 1'b0;
      runon_wr_q    <= 1'b0;
      adj_value_q   <= 8'h00;
    end else begin
      // only block 1 strobes exist on this port
      blk1_on_q     <= accept && ir_cmd_code == CMD_ON;
      blk1_auto_q   <= accept && ir_cmd_code == CMD_AUTO;
      blk1_off_q    <= accept && ir_cmd_code == CMD_OFF;
      twilight_wr_q <= accept && ir_cmd_code == CMD_TWILIGHT;
      sens_wr_q     <= accept && ir_cmd_code == CMD_SENS;
      runon_wr_q    <= accept && ir_cmd_code == CMD_RUNON;
      if (accept) adj_value_q <= ir_cmd_value;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      walk_test_q <= 1'b0;
    end else if (accept && ir_cmd_code == CMD_TEST) begin
      walk_test_q <= ~walk_test_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      accept_cnt_q <= 8'h00;
      reject_cnt_q <= 8'h00;
    end else if (ir_cmd_valid) begin
      if (accept) accept_cnt_q <= accept_cnt_q + 8'h01;
      else reject_cnt_q <= reject_cnt_q + 8'h01;
    end
  end

  property p_blocked_rejects;
    @(posedge aclk) disable iff (!aresetn)
      remote_blocked_q |=> !(blk1_on_q | blk1_auto_q | blk1_off_q | twilight_wr_q);
  endproperty
  a_blocked_rejects: assert property (p_blocked_rejects) else $error("blocked remote acted");

  property p_enable_needed;
    @(posedge aclk) disable iff (!aresetn)
      !cfg_en |=> !(blk1_on_q | sens_wr_q | runon_wr_q);
  endproperty
  a_enable_needed: assert property (p_enable_needed) else $error("remote acted while off");

  property p_no_on;
    @(posedge aclk) disable iff (!aresetn)
      cfg_pre == PRESET_NO_ON |=> !blk1_on_q;
  endproperty
  a_no_on: assert property (p_no_on) else $error("on passed when masked");

  property p_no_off;
    @(posedge aclk) disable iff (!aresetn)
      cfg_pre == PRESET_NO_OFF |=> !blk1_off_q;
  endproperty
  a_no_off: assert property (p_no_off) else $error("off passed when masked");

  property p_test_toggle;
    @(posedge aclk) disable iff (!aresetn)
      accept && ir_cmd_code == CMD_TEST |=> walk_test_q != $past(walk_test_q);
  endproperty
  a_test_toggle: assert property (p_test_toggle) else $error("test did not toggle");

  property p_test_masked;
    @(posedge aclk) disable iff (!aresetn)
      !cfg_test |=> $stable(walk_test_q);
  endproperty
  a_test_masked: assert property (p_test_masked) else $error("test toggled when off");

  property p_unused;
    @(posedge aclk) disable iff (!aresetn)
      !cfg_use |=> !remote_blocked_q;
  endproperty
  a_unused: assert property (p_unused) else $error("disable active unused");

  property p_polarity;
    @(posedge aclk) disable iff (!aresetn)
      cfg_use && obj_wr && !download_done && !bus_return
        |=> remote_blocked_q == ($past(wr_data[0]) ^ $past(cfg_pol));
  endproperty
  a_polarity: assert property (p_polarity) else $error("disable polarity wrong");

  property p_keep;
    @(posedge aclk) disable iff (!aresetn)
      cfg_use && bus_return && !download_done && cfg_ret == RET_KEEP
        |=> remote_blocked_q == $past(saved_block_q);
  endproperty
  a_keep: assert property (p_keep) else $error("saved state not restored");

  property p_download;
    @(posedge aclk) disable iff (!aresetn)
      cfg_use && download_done |=> remote_blocked_q == $past(cfg_dl);
  endproperty
  a_download: assert property (p_download) else $error("download state wrong");

  property p_auto_free;
    @(posedge aclk) disable iff (!aresetn)
      cfg_en && !remote_blocked_q && ir_cmd_valid && ir_cmd_code == CMD_AUTO |=> blk1_auto_q;
  endproperty
  a_auto_free: assert property (p_auto_free) else $error("auto refused");

  property p_return_disabled;
    @(posedge aclk) disable iff (!aresetn)
      cfg_use && bus_return && !download_done && cfg_ret == RET_DISABLED |=> remote_blocked_q;
  endproperty
  a_return_disabled: assert property (p_return_disabled) else $error("return not disabled");

  property p_value_latch;
    @(posedge aclk) disable iff (!aresetn)
      accept |=> adj_value_q == $past(ir_cmd_value);
  endproperty
  a_value_latch: assert property (p_value_latch) else $error("adjust value lost");

  property p_blocked_quiet;
    @(posedge aclk) disable iff (!aresetn)
      remote_blocked_q |=> $stable(walk_test_q) && !(sens_wr_q | runon_wr_q);
  endproperty
  a_blocked_quiet: assert property (p_blocked_quiet) else $error("blocked remote adjusted");

  c_accept: cover property (@(posedge aclk) disable iff (!aresetn) accept);
  c_block:  cover property (@(posedge aclk) disable iff (!aresetn)
    remote_blocked_q && ir_cmd_valid);
  c_test:   cover property (@(posedge aclk) disable iff (!aresetn)
    accept && ir_cmd_code == CMD_TEST);
  c_keep:   cover property (@(posedge aclk) disable iff (!aresetn)
    cfg_use && bus_return && cfg_ret == RET_KEEP);
  c_obj:    cover property (@(posedge aclk) disable iff (!aresetn)
    cfg_use && obj_wr && cfg_pol);

endmodule : remote_control_gate

// ===== testbench/ir_handset.sv
/*
  behavioural infrared handset: turns a bench request into a one-cycle
  decoded command. assumes the gate samples it on the rising edge of aclk.
*/
`timescale 1ns/1ns
module ir_handset (
  // clock
  input  wire logic       aclk,
  // request from the bench
  input  wire logic       send,
  input  wire logic [2:0] code,
  input  wire logic [7:0] value,
  // decoded command toward the gate
  output logic            ir_cmd_valid,
  output logic [2:0]      ir_cmd_code,
  output logic [7:0]      ir_cmd_value
);
  // outside a pulse the fields show the inverse, so stale data never looks valid
  always_ff @(posedge aclk) begin
    ir_cmd_valid <= send;
    ir_cmd_code  <= send ? code : ~code;
    ir_cmd_value <= send ? value : ~value;
  end
endmodule : ir_handset

// ===== testbench/test_remote_control_gate.sv
/*
  self-checking bench for remote_control_gate: table of remote commands,
  then disable, supply and download cases. assumes the gate answers each
  axi request within a few cycles and drives one-cycle strobes.
*/
`timescale 1ns/1ns
module test_remote_control_gate;
  import remote_gate_pkg::*;
  typedef struct packed {logic [8:0] cfg; logic [2:0] code; logic [5:0] st; logic tg;} row_s;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, send, ivalid, bus_fail, bus_return, download_done, blocked;
  logic on_q, auto_q, off_q, walk_q, tw_q, se_q, ro_q, wt;
  logic [7:0] awaddr, araddr, adj, v, ival;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [2:0] c, icode;
  wire [5:0] st = {on_q, auto_q, off_q, tw_q, se_q, ro_q};
  int fail_count, compares, acc, rej;
  row_s rows[16] = '{
    '{9'h000, CMD_ON, 6'h00, 0}, '{9'h001, CMD_ON, 6'h20, 0}, '{9'h001, CMD_AUTO, 6'h10, 0},
    '{9'h001, CMD_OFF, 6'h08, 0}, '{9'h001, CMD_TEST, 6'h00, 0}, '{9'h003, CMD_TEST, 6'h00, 1},
    '{9'h003, CMD_TEST, 6'h00, 1}, '{9'h001, CMD_TWILIGHT, 6'h04, 0},
    '{9'h001, CMD_SENS, 6'h02, 0}, '{9'h001, CMD_RUNON, 6'h01, 0}, '{9'h011, CMD_OFF, 6'h00, 0},
    '{9'h011, CMD_ON, 6'h20, 0}, '{9'h021, CMD_ON, 6'h00, 0}, '{9'h021, CMD_OFF, 6'h08, 0},
    '{9'h021, CMD_AUTO, 6'h10, 0}, '{9'h001, 3'h7, 6'h00, 0}};

  ir_handset hs (.aclk(aclk), .send(send), .code(c), .value(v), .ir_cmd_valid(ivalid),
                 .ir_cmd_code(icode), .ir_cmd_value(ival));
  remote_control_gate dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ir_cmd_valid(ivalid), .ir_cmd_code(icode), .ir_cmd_value(ival),
    .bus_fail(bus_fail), .bus_return(bus_return), .download_done(download_done),
    .blk1_on_q(on_q), .blk1_auto_q(auto_q), .blk1_off_q(off_q), .walk_test_q(walk_q),
    .twilight_wr_q(tw_q), .sens_wr_q(se_q), .runon_wr_q(ro_q), .adj_value_q(adj),
    .remote_blocked_q(blocked));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic print_verdict;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic bound(input int n);
    if (n >= 40) begin
      fail_count++;
      $display("mismatch at %0t: waited %h cycles, limit %h", $time, n, 40);
      print_verdict();
    end
  endtask : bound

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bound(n);
    chk(bresp, er);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    bound(n);
    chk(rdata, ed);
    chk(rresp, er);
    rready <= 1'b0;
  endtask : rd

  // handset needs one edge to launch, the gate one more to answer
  task automatic cmd(input logic [2:0] k, input logic [7:0] val);
    @(posedge aclk);
    send <= 1'b1; c <= k; v <= val;
    @(posedge aclk);
    send <= 1'b0;
    @(posedge aclk);
    #1;
  endtask : cmd

  task automatic pulse(input int k);
    @(posedge aclk);
    case (k)
      0: bus_fail <= 1'b1;
      1: bus_return <= 1'b1;
      default: download_done <= 1'b1;
    endcase
    @(posedge aclk);
    bus_fail <= 1'b0; bus_return <= 1'b0; download_done <= 1'b0;
    @(posedge aclk);
    #1;
  endtask : pulse

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, send, bus_fail, bus_return, download_done} = '0;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'hf; c = 3'h0; v = 8'h00;
    aresetn = 1'b0; wt = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    chk(blocked, 0);
    chk(walk_q, 0);
    rd(CFG_OFF, CFG_RESET, RESP_OKAY);
    rd(8'h20, 32'h0, RESP_SLVERR);
    rd(EVENT_OFF, 32'h0, RESP_OKAY);
    wr(EVENT_OFF, 32'h1, RESP_SLVERR);
    foreach (rows[i]) begin
      wr(CFG_OFF, rows[i].cfg, RESP_OKAY);
      cmd(rows[i].code, 8'h10 + i[7:0]);
      if (rows[i].tg) wt = ~wt;
      chk(st, rows[i].st);
      chk(walk_q, wt);
      if (rows[i].st[2:0] != 3'h0) chk(adj, 8'h10 + i[7:0]);
      if (rows[i].st != 6'h00 || rows[i].tg) acc++;
      else rej++;
    end
    rd(STATUS_OFF, {rej[7:0], acc[7:0]}, RESP_OKAY);
    wr(CFG_OFF, 9'h005, RESP_OKAY);
    wr(BLOCK_OFF, 32'h1, RESP_OKAY);
    chk(blocked, 1);
    rd(BLOCK_OFF, 32'h1, RESP_OKAY);
    cmd(CMD_ON, 8'h01);
    chk(st, 6'h00);
    wr(BLOCK_OFF, 32'h0, RESP_OKAY);
    cmd(CMD_ON, 8'h02);
    chk(st, 6'h20);
    wr(CFG_OFF, 9'h00d, RESP_OKAY);
    wr(BLOCK_OFF, 32'h0, RESP_OKAY);
    chk(blocked, 1);
    wr(BLOCK_OFF, 32'h1, RESP_OKAY);
    chk(blocked, 0);
    wr(CFG_OFF, 9'h001, RESP_OKAY);
    wr(BLOCK_OFF, 32'h1, RESP_OKAY);
    cmd(CMD_AUTO, 8'h03);
    chk(st, 6'h10);
    wr(CFG_OFF, 9'h045, RESP_OKAY);
    pulse(1);
    chk(blocked, 1);
    wr(CFG_OFF, 9'h005, RESP_OKAY);
    pulse(1);
    chk(blocked, 0);
    wr(CFG_OFF, 9'h085, RESP_OKAY);
    wr(BLOCK_OFF, 32'h1, RESP_OKAY);
    pulse(0);
    wr(BLOCK_OFF, 32'h0, RESP_OKAY);
    pulse(1);
    chk(blocked, 1);
    rd(VALUE_OFF, 32'h0000_0103, RESP_OKAY);
    wr(CFG_OFF, 9'h105, RESP_OKAY);
    pulse(2);
    chk(blocked, 1);
    wr(CFG_OFF, 9'h005, RESP_OKAY);
    pulse(2);
    chk(blocked, 0);
    wr(BLOCK_OFF, 32'h1, RESP_OKAY);
    chk(blocked, 1);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CFG_OFF, CFG_RESET, RESP_OKAY);
    chk(blocked, 0);
    chk(adj, 8'h00);
    print_verdict();
  end
endmodule : test_remote_control_gate
